//--- common/scp_pkg.sv
package scp_pkg;

    // ****************************************
    // output modes of the drive port
    // ****************************************
    typedef enum logic [1:0] {
        SCP_OUT_PAR8  = 2'h0,
        SCP_OUT_MUX12 = 2'h1,
        SCP_OUT_PWM   = 2'h2
    } scp_out_mode_t;

    // ****************************************
    // status byte layout and reset values
    // ****************************************
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_INDEX_BIT = 3;
    localparam int unsigned STAT_ALERT_BIT = 6;
    localparam int unsigned STAT_INIT_BIT = 7;
    localparam int unsigned STAT_INIT2_BIT = 2;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] STAT_READY = 8'h84;

    // ****************************************
    // drive port reset codes and timing
    // ****************************************
    localparam logic [11:0] MID12 = 12'h800;
    localparam logic [7:0] MID8 = 8'h80;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned INIT_US = 1000;
    localparam int unsigned INIT_CYC = (CLK_HZ / 1_000_000) * INIT_US;
    localparam int unsigned MID12_HOLD_CYC = 16;
    localparam int unsigned MUX_HALF_CYC = 4;
    localparam int unsigned BUSY_CYC = 4;
    localparam int unsigned SYNC_STAGES = 2;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic a;
        logic b;
        logic idx;
    } scp_enc_t;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic port_select;
    } scp_host_t;

endpackage

//--- src/scp_sync.sv
`timescale 1ns/1ns
module scp_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_sys,              // system clock
    input wire logic sys_rst,              // synchronous reset, high
    input wire logic [WIDTH-1:0] din,      // asynchronous level
    input wire logic [WIDTH-1:0] rst_val,  // constant value held in reset
    output logic [WIDTH-1:0] dout          // synchronised level
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_q <= rst_val;
            sync_q <= rst_val;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule

//--- src/scp_core.sv
`timescale 1ns/1ns
module scp_core #(
    parameter int unsigned POS_W = 32,
    parameter int unsigned INIT_CYCLES = scp_pkg::INIT_CYC
) (
    input wire logic clk_sys,                 // system clock 10 MHz
    input wire logic sys_rst,                 // chip reset, high
    input wire logic rst_pin_n,               // reset pin, low
    input wire scp_pkg::scp_enc_t enc,        // encoder pins
    input wire scp_pkg::scp_host_t host,      // host strobes
    input wire logic [7:0] hd_in,             // host data in
    output logic [7:0] hd_out,                // host data out
    output logic hd_oe,                       // host data enable
    output logic host_alert_output,           // interrupt to host, high
    input wire scp_pkg::scp_out_mode_t mode,  // drive port mode
    input wire logic [11:0] drive_word,       // drive value from filter
    input wire logic [7:0] pwm_mag,           // pwm magnitude from filter
    input wire logic drive_sign,              // pwm sign from filter
    input wire logic index_arm,               // index capture enable
    input wire logic [7:0] irq_enable,        // interrupt enable bits
    input wire logic [7:0] rd_data,           // data port read byte
    output logic [7:0] drive_port,            // drive pins 0 to 7
    output logic [7:0] cmd_byte,              // last command byte
    output logic cmd_valid,                   // command pulse
    output logic [7:0] data_byte,             // last data byte
    output logic data_valid,                  // data write pulse
    output logic data_rd,                     // data read pulse
    output logic [POS_W-1:0] position,        // position count
    output logic [POS_W-1:0] index_pos        // captured index position
);
    if (POS_W < 8 || INIT_CYCLES < 1) begin : g_bad_params
        $error("scp_core: bad parameters");
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [15:0] sync_out;
    logic [7:0] hd_s;
    logic qa, qb, qi, cs_n, rd_n, wr_n, psel, rstp_n;
    scp_sync #(.WIDTH(16)) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .din({enc.a, enc.b, enc.idx, host.cs_n, host.rd_n, host.wr_n, host.port_select,
              rst_pin_n, hd_in}),
        .rst_val(16'h3D00),
        .dout(sync_out)
    );
    assign {qa, qb, qi, cs_n, rd_n, wr_n, psel, rstp_n, hd_s} = sync_out;

    // ****************************************
    // reset pin edge and init sequence
    // ****************************************
    logic rstp_q, init_go, init_busy_q;
    logic [31:0] init_cnt_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rstp_q <= 1'b1;
        end else begin
            rstp_q <= rstp_n;
        end
    end
    assign init_go = rstp_n & ~rstp_q;
    wire in_reset = sys_rst | ~rstp_n;

    always_ff @(posedge clk_sys) begin
        if (in_reset) begin
            init_cnt_q <= 32'h0;
            init_busy_q <= 1'b0;
        end else if (init_go) begin
            init_cnt_q <= 32'h0;
            init_busy_q <= 1'b1;
        end else if (init_busy_q) begin
            if (init_cnt_q == INIT_CYCLES - 1) begin
                init_busy_q <= 1'b0;
            end
            init_cnt_q <= init_cnt_q + 32'h1;
        end
    end

    // ****************************************
    // quadrature decoder
    // ****************************************
    logic [1:0] ab_q;
    logic [POS_W-1:0] pos_q, idx_q;
    logic idx_hit_q;
    wire [1:0] ab = {qa, qb};
    // gray order 00,10,11,01 is forward when a leads b
    wire fwd = (ab_q == 2'h0 && ab == 2'h2) || (ab_q == 2'h2 && ab == 2'h3) ||
               (ab_q == 2'h3 && ab == 2'h1) || (ab_q == 2'h1 && ab == 2'h0);
    wire rev = (ab_q == 2'h2 && ab == 2'h0) || (ab_q == 2'h3 && ab == 2'h2) ||
               (ab_q == 2'h1 && ab == 2'h3) || (ab_q == 2'h0 && ab == 2'h1);
    always_ff @(posedge clk_sys) begin
        if (in_reset) begin
            ab_q <= 2'h0;
            pos_q <= '0;
        end else begin
            ab_q <= ab;
            if (fwd) begin
                pos_q <= pos_q + 1'b1;
            end else if (rev) begin
                pos_q <= pos_q - 1'b1;
            end
        end
    end

    // latch when all three low while armed; level, recaptures every cycle it holds
    wire idx_cond = index_arm & ~qi & ~qa & ~qb;
    always_ff @(posedge clk_sys) begin
        if (in_reset) begin
            idx_q <= '0;
            idx_hit_q <= 1'b0;
        end else if (idx_cond) begin
            idx_q <= pos_q;
            idx_hit_q <= 1'b1;
        end
    end
    assign position = pos_q;
    assign index_pos = idx_q;

    // ****************************************
    // host port
    // ****************************************
    logic rd_q, wr_q, busy_q;
    logic [3:0] busy_cnt_q;
    logic [7:0] status, hd_q;
    wire rd_act = ~cs_n & ~rd_n;
    wire wr_act = ~cs_n & ~wr_n;
    wire wr_end = wr_q & ~wr_act;
    wire rd_end = rd_q & ~rd_act;
    always_ff @(posedge clk_sys) begin
        if (in_reset) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= rd_act;
            wr_q <= wr_act;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (in_reset) begin
            cmd_byte <= 8'h00;
            data_byte <= 8'h00;
        end else if (wr_act & ~wr_q) begin
            if (psel) begin
                data_byte <= hd_s;
            end else begin
                cmd_byte <= hd_s;
            end
        end
    end
    assign cmd_valid = wr_end & ~psel;
    assign data_valid = wr_end & psel;
    assign data_rd = rd_end & psel;

    // busy set on the edge ending a write or a data-port read
    always_ff @(posedge clk_sys) begin
        if (in_reset) begin
            busy_q <= 1'b0;
            busy_cnt_q <= 4'h0;
        end else if (wr_end | (rd_end & psel)) begin
            busy_q <= 1'b1;
            busy_cnt_q <= 4'(scp_pkg::BUSY_CYC);
        end else if (busy_cnt_q != 4'h0) begin
            busy_cnt_q <= busy_cnt_q - 4'h1;
        end else begin
            busy_q <= 1'b0;
        end
    end

    // status 00 until init completes, then 84
    wire init_done = ~init_busy_q & ~in_reset;
    logic ready_q;
    always_ff @(posedge clk_sys) begin
        if (in_reset | init_go) begin
            ready_q <= 1'b0;
        end else if (init_busy_q && init_cnt_q == INIT_CYCLES - 1) begin
            ready_q <= 1'b1;
        end
    end
    always_comb begin
        status = ready_q ? scp_pkg::STAT_READY : scp_pkg::STAT_RESET;
        status[scp_pkg::STAT_BUSY_BIT] = busy_q;
        status[scp_pkg::STAT_INDEX_BIT] = idx_hit_q;
        status[scp_pkg::STAT_ALERT_BIT] = ready_q & idx_hit_q & irq_enable[3];
    end

    always_ff @(posedge clk_sys) begin
        if (in_reset) begin
            hd_q <= 8'h00;
        end else if (rd_act) begin
            hd_q <= psel ? rd_data : status;
        end
    end
    assign hd_out = hd_q;
    // drive only while read strobe active
    assign hd_oe = rd_act & rd_q;

    always_ff @(posedge clk_sys) begin
        if (in_reset) begin
            host_alert_output <= 1'b0;
        end else begin
            host_alert_output <= init_done & |(status & irq_enable & 8'h48);
        end
    end

    // ****************************************
    // drive port
    // ****************************************
    logic [3:0] mux_cnt_q;
    logic mux_hi_q;
    logic mid12_q;
    logic [4:0] mid_cnt_q;
    wire [11:0] dval = mid12_q ? scp_pkg::MID12 :
                       (ready_q ? drive_word : {scp_pkg::MID8, 4'h0});
    // mid-scale 800 then 80 after reset
    always_ff @(posedge clk_sys) begin
        if (in_reset | init_go) begin
            mid12_q <= 1'b1;
            mid_cnt_q <= 5'h0;
        end else if (mid12_q) begin
            if (mid_cnt_q == 5'(scp_pkg::MID12_HOLD_CYC - 1)) begin
                mid12_q <= 1'b0;
            end
            mid_cnt_q <= mid_cnt_q + 5'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (in_reset) begin
            mux_cnt_q <= 4'h0;
            mux_hi_q <= 1'b0;
        end else if (mux_cnt_q == 4'(2 * scp_pkg::MUX_HALF_CYC - 1)) begin
            mux_cnt_q <= 4'h0;
            mux_hi_q <= ~mux_hi_q;
        end else begin
            mux_cnt_q <= mux_cnt_q + 4'h1;
        end
    end
    // strobe rises mid-half so the word is settled first
    wire mux_strobe = (mux_cnt_q >= 4'(scp_pkg::MUX_HALF_CYC));

    always_ff @(posedge clk_sys) begin
        if (in_reset) begin
            drive_port <= scp_pkg::MID8;
        end else begin
            case (mode)
                scp_pkg::SCP_OUT_PAR8: begin
                    drive_port <= mid12_q ? scp_pkg::MID8 : dval[11:4];
                end
                scp_pkg::SCP_OUT_MUX12: begin
                    drive_port <= {(mux_hi_q ? dval[11:6] : dval[5:0]), mux_hi_q,
                                   mux_strobe};
                end
                scp_pkg::SCP_OUT_PWM: begin
                    drive_port <= {drive_sign, (mux_cnt_q < pwm_mag[7:4]), 6'h00};
                end
                default: begin
                    drive_port <= scp_pkg::MID8;
                end
            endcase
        end
    end
endmodule

//--- dv/scp_core_sva.sv
`timescale 1ns/1ns
module scp_core_chk (
    input wire logic clk_sys, // clock
    input wire logic sys_rst, // reset
    input wire scp_pkg::scp_host_t host, // strobes
    input wire logic hd_oe, // bus enable
    input wire logic host_alert_output, // alert
    input wire scp_pkg::scp_out_mode_t mode, // drive mode
    input wire logic [11:0] drive_word, // drive value
    input wire logic [7:0] irq_enable, // enables
    input wire logic [7:0] drive_port, // drive pins
    input wire logic cmd_valid, // command pulse
    input wire logic data_valid // data pulse
);
    // ****
    // steady drive word
    // ****
    logic [5:0] st_q;
    logic steady;
    // init codes override the word for a while after reset
    assign steady = mode == scp_pkg::SCP_OUT_MUX12 && st_q == 6'h3F;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || $changed(mode) || $changed(drive_word)) begin
            st_q <= 6'h00;
        end else if (st_q != 6'h3F) begin
            st_q <= st_q + 6'h01;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    reset_code_a: assert property (disable iff (1'b0) sys_rst |=> drive_port == 8'h80 && !hd_oe)
        else $error("drive port not mid code in reset");
    oe_read_only_a: assert property (host.rd_n [*6] |=> !hd_oe)
        else $error("bus driven without read");
    cs_gate_a: assert property (host.cs_n [*5] |-> !cmd_valid && !data_valid)
        else $error("access taken without select");
    cmd_port_a: assert property (cmd_valid |-> !host.port_select)
        else $error("command taken on data port");
    data_port_a: assert property (data_valid |-> host.port_select)
        else $error("data taken on command port");
    alert_cause_a: assert property ($rose(host_alert_output) |-> $past(irq_enable[3]))
        else $error("alert without enable");
    mux_value_a: assert property (steady && $rose(drive_port[0]) |->
        drive_port[7:2] == (drive_port[1] ? drive_word[11:6] : drive_word[5:0]))
        else $error("mux half wrong");
    mux_order_a: assert property (steady && $rose(drive_port[0]) && !drive_port[1] |->
        ##8 ($rose(drive_port[0]) && drive_port[1]))
        else $error("high half not after low half");
    cover property (cmd_valid);
    cover property (data_valid);
    cover property ($rose(host_alert_output));
endmodule
bind scp_core scp_core_chk chk (.clk_sys, .sys_rst, .host, .hd_oe, .host_alert_output,
    .mode, .drive_word, .irq_enable, .drive_port, .cmd_valid, .data_valid);

//--- dv/scp_host_bfm.sv
`timescale 1ns/1ns
module scp_host_bfm (
    input wire logic clk_sys, // clock
    output scp_pkg::scp_host_t host, // strobes
    output logic [7:0] hd_in, // wire level
    input wire logic [7:0] hd_out, // device data
    input wire logic hd_oe // device drives
);
    // ****
    // host port
    // ****
    logic drv = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] last_q = 8'h00;
    initial host = 4'hE;
    // undriven wire keeps moving so stale data never matches
    assign hd_in = hd_oe ? hd_out : (drv ? wd : ~last_q);
    always @(posedge clk_sys) last_q <= hd_in;
    task automatic access(input logic sel, input logic wr, input logic ps,
        input logic [7:0] d, output logic [7:0] q);
        host.port_select = ps;
        host.cs_n = !sel;
        drv = wr;
        wd = d;
        @(posedge clk_sys);
        #10;
        if (wr) host.wr_n = 1'b0;
        else host.rd_n = 1'b0;
        repeat (8) @(posedge clk_sys);
        #10;
        // take the wire level so a missing bus enable shows up
        q = hd_in;
        host.wr_n = 1'b1;
        host.rd_n = 1'b1;
        @(posedge clk_sys);
        #10;
        host.cs_n = 1'b1;
        drv = 1'b0;
        repeat (4) @(posedge clk_sys);
        #10;
    endtask
endmodule

//--- dv/scp_core_tb.sv
`timescale 1ns/1ns
module scp_core_tb;
    // ****
    // bench
    // ****
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic rst_pin_n = 1'b0;
    scp_pkg::scp_enc_t enc = 3'b001;
    scp_pkg::scp_host_t host;
    logic [7:0] hd_in, hd_out, q, dport, cmd, dat;
    logic hd_oe, alert, cv, dv, dr;
    scp_pkg::scp_out_mode_t mode = scp_pkg::SCP_OUT_PAR8;
    logic [11:0] word = 12'h800;
    logic sign = 1'b0;
    logic arm = 1'b0;
    logic [7:0] irq = 8'h00;
    logic [7:0] rdd = 8'h3C;
    logic [7:0] mag = 8'h40;
    logic [31:0] pos, ipos;
    int n_fail = 0;
    int check_count = 0;
    int n_cmd = 0;
    int n_dv = 0;
    int n_dr = 0;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        n_cmd += int'(cv);
        n_dv += int'(dv);
        n_dr += int'(dr);
    end
    scp_core #(.POS_W(32), .INIT_CYCLES(20)) dut (.clk_sys, .sys_rst, .rst_pin_n, .enc,
        .host, .hd_in, .hd_out, .hd_oe, .host_alert_output(alert), .mode,
        .drive_word(word), .pwm_mag(mag), .drive_sign(sign), .index_arm(arm),
        .irq_enable(irq), .rd_data(rdd), .drive_port(dport), .cmd_byte(cmd),
        .cmd_valid(cv), .data_byte(dat), .data_valid(dv), .data_rd(dr), .position(pos),
        .index_pos(ipos));
    scp_host_bfm hm (.clk_sys, .host, .hd_in, .hd_out, .hd_oe);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic walk(input logic [7:0] seq);
        for (int i = 3; i >= 0; i--) begin
            enc.a = seq[2*i+1];
            enc.b = seq[2*i];
            repeat (10) @(posedge clk_sys);
            #10;
        end
    endtask
    task automatic half(input logic dm, input logic [5:0] exp);
        logic p;
        p = 1'b1;
        for (int i = 0; i < 60; i++) begin
            @(posedge clk_sys);
            if (!p && dport[0] && dport[1] === dm) break;
            p = dport[0];
        end
        chk(32'(dport[7:2]), 32'(exp));
        #10;
    endtask
    task automatic t_reset;
        repeat (3) @(posedge clk_sys);
        #10;
        sys_rst = 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(32'(dport), 32'(scp_pkg::MID8));
        #10;
        rst_pin_n = 1'b1;
        hm.access(1, 0, 0, 8'h00, q);
        chk(32'(q), 32'(scp_pkg::STAT_RESET));
        repeat (40) @(posedge clk_sys);
        hm.access(1, 0, 0, 8'h00, q);
        chk(32'(q), 32'(scp_pkg::STAT_READY));
        $display("reset test done");
    endtask
    task automatic t_host;
        hm.access(1, 1, 0, 8'hA5, q);
        chk(32'(cmd), 32'hA5);
        hm.access(0, 1, 0, 8'h5A, q);
        chk(32'(cmd), 32'hA5);
        chk(32'(n_cmd), 32'h1);
        hm.access(1, 1, 1, 8'hC3, q);
        chk(32'(dat), 32'hC3);
        chk(32'(n_dv), 32'h1);
        hm.access(1, 0, 1, 8'h00, q);
        chk(32'(q), 32'(rdd));
        chk(32'(n_dr), 32'h1);
        hm.access(1, 0, 0, 8'h00, q);
        chk(32'(q), 32'(scp_pkg::STAT_READY));
        $display("host test done");
    endtask
    task automatic t_enc;
        walk(8'hB4);
        walk(8'hB4);
        chk(pos, 32'h8);
        walk(8'h78);
        chk(pos, 32'h4);
        walk(8'hCC);
        chk(pos, 32'h4);
        arm = 1'b1;
        irq = 8'h08;
        walk(8'hB4);
        enc.idx = 1'b0;
        repeat (10) @(posedge clk_sys);
        #10;
        enc.idx = 1'b1;
        chk(ipos, 32'h8);
        chk(32'(alert), 32'h1);
        hm.access(1, 0, 0, 8'h00, q);
        chk(32'(q), 32'hCC);
        $display("encoder test done");
    endtask
    task automatic mag_count(output int n);
        n = 0;
        repeat (16) begin
            @(posedge clk_sys);
            n += int'(dport[6]);
        end
    endtask
    task automatic t_drive;
        int n;
        word = 12'hABC;
        repeat (3) @(posedge clk_sys);
        chk(32'(dport), 32'hAB);
        #10;
        mode = scp_pkg::SCP_OUT_MUX12;
        // the mux checks need the word steady for 63 clocks first
        repeat (70) @(posedge clk_sys);
        half(1'b0, 6'h3C);
        half(1'b1, 6'h2A);
        mode = scp_pkg::SCP_OUT_PWM;
        sign = 1'b1;
        repeat (20) @(posedge clk_sys);
        chk(32'(dport[7]), 32'h1);
        chk(32'(dport[5:0]), 32'h0);
        mag_count(n);
        chk(32'(n > 0 && n < 16), 32'h1);
        #10;
        sign = 1'b0;
        mag = 8'h00;
        repeat (20) @(posedge clk_sys);
        chk(32'(dport[7]), 32'h0);
        mag_count(n);
        chk(32'(n), 32'h0);
        $display("drive test done");
    endtask
    initial begin
        t_reset();
        t_host();
        t_enc();
        t_drive();
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_fail++;
        stop_test();
    end
endmodule
